/* File: design/fct_map.svh */
`ifndef FCT_MAP_SVH
`define FCT_MAP_SVH

// Clock and common time base.
`define FCT_CLK_PERIOD_NS 4
`define FCT_TICK_PERIOD_NS 1000000
`define FCT_TICK_CYCLES (`FCT_TICK_PERIOD_NS / `FCT_CLK_PERIOD_NS)

// Register groups: byte address bits [8:5]; channel in bits [4:2].
`define FCT_GRP_TMR_CFG 4'h2
`define FCT_GRP_TOT_CFG 4'h4
`define FCT_GRP_TOT_FSL 4'h5
`define FCT_GRP_TOT_VAL 4'h6
`define FCT_GRP_TOT_ACC 4'h7
`define FCT_GRP_CMP_CFG 4'h8
`define FCT_GRP_CMP_SP 4'h9
`define FCT_GRP_CMP_DEV 4'ha
`define FCT_GRP_MISC 4'hb
`define FCT_MISC_SEQ_CFG 3'h0
`define FCT_MISC_SEQ_REQ 3'h1
`define FCT_MISC_STATUS 3'h2

// Accumulator ceilings.
`define FCT_ACC_MAX_LARGE 24'h98_967f
`define FCT_ACC_MAX_SMALL 24'h00_7fff

// Sequencer limits.
`define FCT_SEQ_FULL 7'h64
`define FCT_SEQ_STAGES 5'h08
`define FCT_SEQ_STAGES_LINKED 5'h10

// Reset values.
`define FCT_RST_WORD 32'h0000_0000
`define FCT_RST_FSL 32'hffff_ffff

`endif

/* File: design/fct_pkg.sv */
package fct_pkg;

   // Timer function of a channel.
   typedef enum logic [2:0] {
      FCT_TMR_PULSE,
      FCT_TMR_RETRIG,
      FCT_TMR_ON_MEM,
      FCT_TMR_ON_DELAY,
      FCT_TMR_OFF_DELAY
   } fct_tmr_mode_type;

   // Totalizer function of a channel.
   typedef enum logic [1:0] {
      FCT_TOT_EVENT,
      FCT_TOT_INTEG,
      FCT_TOT_TIME
   } fct_tot_mode_type;

   // Timer channel configuration word.
   typedef struct packed {
      logic [15:0] period;
      logic [9:0] unused;
      logic hold_out;
      logic hold;
      logic pad;
      fct_tmr_mode_type mode;
   } fct_tmr_cfg_type;

   // Totalizer channel configuration word.
   typedef struct packed {
      logic [15:0] rate;
      logic [10:0] unused;
      logic hold;
      logic acc_small;
      logic wrap;
      fct_tot_mode_type mode;
   } fct_tot_cfg_type;

   // Comparator channel configuration word.
   typedef struct packed {
      logic [28:0] unused;
      logic hold;
      logic use_var;
      logic below;
   } fct_cmp_cfg_type;

   // Sequencer configuration word.
   typedef struct packed {
      logic [6:0] step;
      logic [17:0] unused;
      logic hold;
      logic use_logic;
      logic link;
      logic [3:0] stages;
   } fct_seq_cfg_type;

endpackage

/* File: design/fct_top.sv */
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "fct_map.svh"

module fct_top #(
   parameter int TICK_CYCLES = `FCT_TICK_CYCLES,
   parameter int CHANNELS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [CHANNELS-1:0] tmr_in_i,
   input wire logic [CHANNELS-1:0] tmr_rst_i,
   output logic [CHANNELS-1:0] tmr_out_o,
   input wire logic [CHANNELS-1:0] tot_in_i,
   input wire logic [CHANNELS-1:0] tot_rst_i,
   input wire logic [CHANNELS-1:0][15:0] tot_num_i,
   output logic [CHANNELS-1:0][31:0] total_value_out_o,
   output logic [CHANNELS-1:0] full_scale_flag_o,
   output logic [CHANNELS-1:0][23:0] overflow_accumulator_o,
   input wire logic [CHANNELS-1:0][15:0] cmp_ain_i,
   input wire logic [CHANNELS-1:0][15:0] cmp_var_i,
   output logic [CHANNELS-1:0] cmp_flag_o,
   output logic [CHANNELS-1:0][16:0] cmp_dev_o,
   input wire logic [7:0] seq_demand_i,
   input wire logic seq_up_i,
   input wire logic seq_down_i,
   input wire logic [15:0] seq_disable_i,
   output logic [15:0] seq_out_o,
   output logic [6:0] seq_req_o
);

   fct_pkg::fct_tmr_cfg_type [CHANNELS-1:0] tmr_cfg_q;
   fct_pkg::fct_tot_cfg_type [CHANNELS-1:0] tot_cfg_q;
   logic [CHANNELS-1:0][31:0] tot_fsl_q;
   fct_pkg::fct_cmp_cfg_type [CHANNELS-1:0] cmp_cfg_q;
   logic [CHANNELS-1:0][15:0] cmp_sp_q;
   fct_pkg::fct_seq_cfg_type seq_cfg_q;
   logic [31:0] tb_cnt_q;
   logic tick_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic access;
   logic wr_en;
   logic [3:0] grp;
   logic [2:0] chn;
   logic [CHANNELS-1:0] wr_tot_val;
   logic [CHANNELS-1:0] wr_tot_acc;
   logic [CHANNELS-1:0] wr_cmp_dev;
   logic wr_seq_req;

   // Merge a write under its byte enables.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // A request is served once; ack follows one cycle after the strobe.
   assign access = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_en = access && wb_we_i;
   assign grp = wb_adr_i[8:5];
   assign chn = wb_adr_i[4:2];
   assign wr_seq_req = wr_en && grp == `FCT_GRP_MISC &&
                       chn == `FCT_MISC_SEQ_REQ;

   // Per-channel write strobes for registers the channel logic owns.
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         wr_tot_val[i] = wr_en && grp == `FCT_GRP_TOT_VAL && chn == i;
         wr_tot_acc[i] = wr_en && grp == `FCT_GRP_TOT_ACC && chn == i;
         wr_cmp_dev[i] = wr_en && grp == `FCT_GRP_CMP_DEV && chn == i;
      end
   end

   // Common time base; every period counts these ticks.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || tb_cnt_q == TICK_CYCLES - 1)
      begin
         tb_cnt_q <= `FCT_RST_WORD;
      end
      else
      begin
         tb_cnt_q <= tb_cnt_q + 32'h0000_0001;
      end
      tick_q <= !rst_i && tb_cnt_q == TICK_CYCLES - 1;
   end

   // Bus handshake: ack is a single cycle per request.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= access;
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tmr_cfg_q <= '0;
         tot_cfg_q <= '0;
         cmp_cfg_q <= '0;
         cmp_sp_q <= '0;
         seq_cfg_q <= '0;
         for (int i = 0; i < CHANNELS; i++)
         begin
            tot_fsl_q[i] <= `FCT_RST_FSL;
         end
      end
      else if (wr_en)
      begin
         case (grp)
            `FCT_GRP_TMR_CFG: tmr_cfg_q[chn] <=
               merge(tmr_cfg_q[chn], wb_dat_i, wb_sel_i);
            `FCT_GRP_TOT_CFG: tot_cfg_q[chn] <=
               merge(tot_cfg_q[chn], wb_dat_i, wb_sel_i);
            `FCT_GRP_TOT_FSL: tot_fsl_q[chn] <=
               merge(tot_fsl_q[chn], wb_dat_i, wb_sel_i);
            `FCT_GRP_CMP_CFG: cmp_cfg_q[chn] <=
               merge(cmp_cfg_q[chn], wb_dat_i, wb_sel_i);
            `FCT_GRP_CMP_SP: cmp_sp_q[chn] <=
               16'(merge({16'h0000, cmp_sp_q[chn]}, wb_dat_i, wb_sel_i));
            `FCT_GRP_MISC:
            begin
               if (chn == `FCT_MISC_SEQ_CFG)
               begin
                  seq_cfg_q <= merge(seq_cfg_q, wb_dat_i, wb_sel_i);
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero but are still acknowledged.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_q <= `FCT_RST_WORD;
      end
      else if (access)
      begin
         case (grp)
            `FCT_GRP_TMR_CFG: rdata_q <= tmr_cfg_q[chn];
            `FCT_GRP_TOT_CFG: rdata_q <= tot_cfg_q[chn];
            `FCT_GRP_TOT_FSL: rdata_q <= tot_fsl_q[chn];
            `FCT_GRP_TOT_VAL: rdata_q <= total_value_out_o[chn];
            `FCT_GRP_TOT_ACC: rdata_q <=
               {8'h00, overflow_accumulator_o[chn]};
            `FCT_GRP_CMP_CFG: rdata_q <= cmp_cfg_q[chn];
            `FCT_GRP_CMP_SP: rdata_q <= {16'h0000, cmp_sp_q[chn]};
            `FCT_GRP_CMP_DEV: rdata_q <=
               {{15{cmp_dev_o[chn][16]}}, cmp_dev_o[chn]};
            `FCT_GRP_MISC:
            begin
               case (chn)
                  `FCT_MISC_SEQ_CFG: rdata_q <= seq_cfg_q;
                  `FCT_MISC_SEQ_REQ: rdata_q <= {25'h000_0000, seq_req_o};
                  `FCT_MISC_STATUS: rdata_q <= {8'h00, cmp_flag_o,
                     full_scale_flag_o, tmr_out_o};
                  default: rdata_q <= `FCT_RST_WORD;
               endcase
            end
            default: rdata_q <= `FCT_RST_WORD;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : chan
         logic tin_q;
         logic run_q;
         logic [15:0] tcnt_q;
         logic t_out_q;
         logic t_rise;
         logic t_reach;
         logic [15:0] tcnt_inc;

         assign t_rise = tmr_in_i[g] && !tin_q;
         assign tcnt_inc = tcnt_q + 16'h0001;
         assign t_reach = tick_q && tcnt_inc >= tmr_cfg_q[g].period;

         // Timer algorithm state.
         always_ff @(posedge clk_i)
         begin
            tin_q <= rst_i ? 1'b0 : tmr_in_i[g];
            if (rst_i || tmr_rst_i[g])
            begin
               t_out_q <= 1'b0;
               run_q <= 1'b0;
               tcnt_q <= 16'h0000;
            end
            else
            begin
               if (run_q && tick_q)
               begin
                  tcnt_q <= tcnt_inc;
               end
               case (tmr_cfg_q[g].mode)
                  fct_pkg::FCT_TMR_PULSE:
                  begin
                     if (!run_q && t_rise)
                     begin
                        t_out_q <= 1'b1;
                        run_q <= 1'b1;
                        tcnt_q <= 16'h0000;
                     end
                     else if (run_q && t_reach)
                     begin
                        t_out_q <= 1'b0;
                        run_q <= 1'b0;
                     end
                  end
                  fct_pkg::FCT_TMR_RETRIG:
                  begin
                     if (t_rise)
                     begin
                        t_out_q <= 1'b1;
                        run_q <= 1'b1;
                        tcnt_q <= 16'h0000;
                     end
                     else if (run_q && t_reach)
                     begin
                        t_out_q <= 1'b0;
                        run_q <= 1'b0;
                     end
                  end
                  fct_pkg::FCT_TMR_ON_MEM, fct_pkg::FCT_TMR_ON_DELAY:
                  begin
                     if (!tmr_in_i[g])
                     begin
                        run_q <= 1'b0;
                        if (tmr_cfg_q[g].mode == fct_pkg::FCT_TMR_ON_DELAY)
                        begin
                           t_out_q <= 1'b0;
                        end
                     end
                     else if (t_rise)
                     begin
                        run_q <= 1'b1;
                        tcnt_q <= 16'h0000;
                     end
                     else if (run_q && t_reach)
                     begin
                        t_out_q <= 1'b1;
                        run_q <= 1'b0;
                     end
                  end
                  fct_pkg::FCT_TMR_OFF_DELAY:
                  begin
                     if (tmr_in_i[g])
                     begin
                        t_out_q <= 1'b1;
                        run_q <= 1'b0;
                     end
                     else if (tin_q)
                     begin
                        run_q <= 1'b1;
                        tcnt_q <= 16'h0000;
                     end
                     else if (run_q && t_reach)
                     begin
                        t_out_q <= 1'b0;
                        run_q <= 1'b0;
                     end
                  end
                  default:
                  begin
                     t_out_q <= 1'b0;
                     run_q <= 1'b0;
                  end
               endcase
            end
         end

         // In hold the pin shows the supervisor's value, not the timer.
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               tmr_out_o[g] <= 1'b0;
            end
            else
            begin
               tmr_out_o[g] <= tmr_cfg_q[g].hold ?
                  tmr_cfg_q[g].hold_out : t_out_q;
            end
         end

         logic zin_q;
         logic [15:0] rate_q;
         logic [31:0] inc;
         logic step;
         logic [32:0] sum;
         logic [23:0] acc_max;

         assign acc_max = tot_cfg_q[g].acc_small ?
            `FCT_ACC_MAX_SMALL : `FCT_ACC_MAX_LARGE;
         assign sum = {1'b0, total_value_out_o[g]} + {1'b0, inc};

         // Increment source per totalizer mode.
         always_comb
         begin
            step = 1'b0;
            inc = 32'h0000_0000;
            case (tot_cfg_q[g].mode)
               fct_pkg::FCT_TOT_EVENT:
               begin
                  step = tot_in_i[g] && !zin_q;
                  inc = {16'h0000, tot_cfg_q[g].rate};
               end
               fct_pkg::FCT_TOT_INTEG:
               begin
                  step = tick_q && rate_q >= tot_cfg_q[g].rate;
                  inc = {16'h0000, tot_num_i[g]};
               end
               fct_pkg::FCT_TOT_TIME:
               begin
                  step = tick_q && tot_in_i[g] &&
                     rate_q >= tot_cfg_q[g].rate;
                  inc = 32'h0000_0001;
               end
               default:
               begin
               end
            endcase
         end

         // Rate divider counts ticks up to the channel time constant.
         always_ff @(posedge clk_i)
         begin
            zin_q <= rst_i ? 1'b0 : tot_in_i[g];
            if (rst_i || tot_rst_i[g] || step)
            begin
               rate_q <= 16'h0000;
            end
            else if (tick_q && (tot_cfg_q[g].mode != fct_pkg::FCT_TOT_TIME
                     || tot_in_i[g]))
            begin
               rate_q <= rate_q + 16'h0001;
            end
         end

         // Total, flag and accumulator.
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               total_value_out_o[g] <= `FCT_RST_WORD;
               full_scale_flag_o[g] <= 1'b0;
               overflow_accumulator_o[g] <= 24'h00_0000;
            end
            else
            begin
               if (wr_tot_acc[g])
               begin
                  overflow_accumulator_o[g] <= 24'h00_0000;
               end
               if (tot_rst_i[g])
               begin
                  total_value_out_o[g] <= `FCT_RST_WORD;
                  full_scale_flag_o[g] <= 1'b0;
               end
               else if (tot_cfg_q[g].hold)
               begin
                  if (wr_tot_val[g])
                  begin
                     total_value_out_o[g] <= wb_dat_i;
                  end
               end
               else if (step && !full_scale_flag_o[g])
               begin
                  if (sum >= {1'b0, tot_fsl_q[g]})
                  begin
                     if (tot_cfg_q[g].wrap)
                     begin
                        total_value_out_o[g] <= `FCT_RST_WORD;
                        if (overflow_accumulator_o[g] < acc_max)
                        begin
                           overflow_accumulator_o[g] <=
                              overflow_accumulator_o[g] + 24'h00_0001;
                        end
                     end
                     else
                     begin
                        total_value_out_o[g] <= tot_fsl_q[g];
                        full_scale_flag_o[g] <= 1'b1;
                     end
                  end
                  else
                  begin
                     total_value_out_o[g] <= sum[31:0];
                  end
               end
            end
         end

         logic signed [15:0] sp;
         logic signed [16:0] dev;

         assign sp = cmp_cfg_q[g].use_var ?
            $signed(cmp_var_i[g]) : $signed(cmp_sp_q[g]);
         assign dev = $signed({cmp_ain_i[g][15], cmp_ain_i[g]}) -
            $signed({sp[15], sp});

         // Comparator flag and deviation.
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               cmp_flag_o[g] <= 1'b0;
               cmp_dev_o[g] <= 17'h0_0000;
            end
            else
            begin
               cmp_flag_o[g] <= cmp_cfg_q[g].below ?
                  $signed(cmp_ain_i[g]) < sp :
                  $signed(cmp_ain_i[g]) > sp;
               if (!cmp_cfg_q[g].hold)
               begin
                  cmp_dev_o[g] <= dev;
               end
               else if (wr_cmp_dev[g])
               begin
                  cmp_dev_o[g] <= wb_dat_i[16:0];
               end
            end
         end
      end
   endgenerate

   logic [4:0] lim;
   logic [4:0] nst;
   logic [10:0] prod;
   logic [4:0] on_cnt;
   logic [7:0] up_sum;

   // Stage count is capped at eight unless the pair is linked.
   assign lim = seq_cfg_q.link ? `FCT_SEQ_STAGES_LINKED
                               : `FCT_SEQ_STAGES;
   assign nst = ({1'b0, seq_cfg_q.stages} + 5'h01 > lim) ? lim :
                {1'b0, seq_cfg_q.stages} + 5'h01;
   assign prod = {4'h0, seq_req_o} * {6'h00, nst};
   assign on_cnt = 5'(prod / 11'(`FCT_SEQ_FULL));
   assign up_sum = {1'b0, seq_req_o} + {1'b0, seq_cfg_q.step};

   // Required output: analog percent, or stepped by the two inputs.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         seq_req_o <= 7'h00;
      end
      else if (seq_cfg_q.hold)
      begin
         if (wr_seq_req)
         begin
            seq_req_o <= wb_dat_i[6:0];
         end
      end
      else if (!seq_cfg_q.use_logic)
      begin
         seq_req_o <= (seq_demand_i > {1'b0, `FCT_SEQ_FULL}) ?
            `FCT_SEQ_FULL : seq_demand_i[6:0];
      end
      else if (tick_q && seq_up_i)
      begin
         seq_req_o <= (up_sum > {1'b0, `FCT_SEQ_FULL}) ?
            `FCT_SEQ_FULL : up_sum[6:0];
      end
      else if (tick_q && seq_down_i)
      begin
         seq_req_o <= (seq_req_o < seq_cfg_q.step) ? 7'h00 :
            seq_req_o - seq_cfg_q.step;
      end
   end

   // Stage outputs; a disabled stage is held off.
   always_ff @(posedge clk_i)
   begin
      for (int s = 0; s < 16; s++)
      begin
         seq_out_o[s] <= !rst_i && 5'(s) < on_cnt &&
            !seq_disable_i[s];
      end
   end

endmodule

/* File: testbench/fct_props.sv */
`timescale 1ns/1ps
module fct_props #(
   parameter int TICK_CYCLES = 4,
   parameter int CHANNELS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [CHANNELS-1:0] tot_rst_i,
   input wire logic [CHANNELS-1:0][31:0] total_value_out_o,
   input wire logic [CHANNELS-1:0] full_scale_flag_o,
   input wire logic [CHANNELS-1:0][23:0] overflow_accumulator_o,
   input wire logic [15:0] seq_disable_i,
   input wire logic [15:0] seq_out_o,
   input wire logic [6:0] seq_req_o
);
   // Everything is judged on the one block clock, quiet during reset.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("bus request not answered on the next edge");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("bus ack longer than one cycle");
   property p_tot_rst;
      tot_rst_i[0] |-> ##[1:2] total_value_out_o[0] == 32'h0000_0000;
   endproperty
   a_tot_rst: assert property (p_tot_rst)
      else $error("channel reset left a nonzero total");
   // The past term skips the edge where a late reset is still landing.
   property p_fs_keep;
      full_scale_flag_o[0] && !tot_rst_i[0] && !$past(tot_rst_i[0])
         |=> full_scale_flag_o[0];
   endproperty
   a_fs_keep: assert property (p_fs_keep)
      else $error("full scale flag dropped without reset");
   property p_acc_max;
      overflow_accumulator_o[0] <= 24'h98_967f;
   endproperty
   a_acc_max: assert property (p_acc_max)
      else $error("accumulator above its ceiling");
   property p_acc_step;
      $changed(overflow_accumulator_o[0]) |->
         overflow_accumulator_o[0] == $past(overflow_accumulator_o[0]) +
         24'h00_0001 || overflow_accumulator_o[0] == 24'h00_0000;
   endproperty
   a_acc_step: assert property (p_acc_step)
      else $error("accumulator moved by other than one");
   property p_seq_dis;
      seq_disable_i[0] |=> !seq_out_o[0];
   endproperty
   a_seq_dis: assert property (p_seq_dis)
      else $error("disabled stage switched on");
   property p_seq_zero;
      seq_req_o == 7'h00 |=> seq_out_o == 16'h0000;
   endproperty
   a_seq_zero: assert property (p_seq_zero)
      else $error("stage on with zero demand");
endmodule
bind fct_top fct_props #(.TICK_CYCLES(TICK_CYCLES), .CHANNELS(CHANNELS))
   u_fct_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tot_rst_i,
   .total_value_out_o, .full_scale_flag_o, .overflow_accumulator_o,
   .seq_disable_i, .seq_out_o, .seq_req_o);

/* File: testbench/fct_pts.sv */
`timescale 1ns/1ps
module fct_pts (
   input wire logic clk_i,
   input wire logic [15:0] ain_i,
   input wire logic [15:0] var_i,
   input wire logic [15:0] num_i,
   output logic [7:0][15:0] ain_o,
   output logic [7:0][15:0] var_o,
   output logic [7:0][15:0] num_o
);
   // Connected points are scanned once a clock, so values lag by one edge.
   always_ff @(posedge clk_i)
   begin
      ain_o <= {8{ain_i}};
      var_o <= {8{var_i}};
      num_o <= {8{num_i}};
   end
endmodule

/* File: testbench/fct_top_bench.sv */
`timescale 1ns/1ps
module fct_top_bench;
   localparam logic [31:0] z = 32'h0000_0000;
   logic clk_i = 0;
   logic rst_i = 1;
   logic cyc = 0;
   logic we = 0;
   logic ack;
   logic [3:0] sel = 4'h0;
   logic [8:0] adr = 9'h000;
   logic [31:0] dat = z, rd, rdo, v0;
   logic [7:0] ti = 8'h00, tr = 8'h00, tn = 8'h00, tz = 8'h00, to, fs, cf;
   logic [7:0] dem = 8'h00;
   logic up = 1'b0, dn = 1'b0;
   logic [15:0] a = 16'h0000, v = 16'h0000, dis = 16'h0000, so;
   logic [6:0] sr;
   logic [7:0][15:0] ain, vr, num;
   logic [7:0][31:0] total_value_out;
   logic [7:0][23:0] acc;
   logic [7:0][16:0] dev;
   int n_errors = 0;
   int num_checks = 0;
   int cnt = 0;

   fct_pts u_fct_pts (.clk_i, .ain_i(a), .var_i(v), .num_i(16'h0005),
      .ain_o(ain), .var_o(vr), .num_o(num));
   fct_top #(.TICK_CYCLES(4)) u_fct_top (.clk_i, .rst_i, .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(sel), .wb_dat_o(rdo), .wb_ack_o(ack), .tmr_in_i(ti),
      .tmr_rst_i(tr), .tmr_out_o(to), .tot_in_i(tn), .tot_rst_i(tz),
      .tot_num_i(num), .total_value_out_o(total_value_out), .full_scale_flag_o(fs),
      .overflow_accumulator_o(acc), .cmp_ain_i(ain), .cmp_var_i(vr),
      .cmp_flag_o(cf), .cmp_dev_o(dev), .seq_demand_i(dem),
      .seq_up_i(up), .seq_down_i(dn), .seq_disable_i(dis),
      .seq_out_o(so), .seq_req_o(sr));

   always #2 clk_i = ~clk_i;

   // A stuck handshake still ends in the closing report.
   always @(posedge clk_i)
   begin
      cnt <= cnt + 1;
      if (cnt == 5000)
      begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Outputs are read at the edge, before the design's own updates land.
   task automatic chk(input string s, input logic [31:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask

   // Classic single cycle; the request stands until ack is seen at an edge.
   task automatic wb(input logic wr, input logic [8:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= wr;
      adr <= ad;
      dat <= d;
      sel <= 4'hf;
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      rd = rdo;
      cyc <= 1'b0;
   endtask

   task automatic ev(input int n);
      repeat (n)
      begin
         tn <= 8'hff;
         w(1);
         tn <= 8'h00;
         w(1);
      end
      w(3);
   endtask

   task automatic clr();
      tz <= 8'hff;
      w(1);
      tz <= 8'h00;
      w(3);
   endtask

   task automatic t_regs();
      wb(0, 9'h0a4, z);
      chk("fsl", rd, 32'hffff_ffff);
      wb(0, 9'h1fc, z);
      chk("unmapped", rd, z);
   endtask

   task automatic t_tmr();
      for (int i = 0; i < 5; i++)
         wb(1, 9'h040 + 9'(4 * i), 32'h0008_0000 + 32'(i));
      ti <= 8'hff;
      w(4);
      chk("tmr", 32'(to[4:0]), 32'h0000_0013);
      ti <= 8'h00;
      w(6);
      ti <= 8'hff;
      w(2);
      ti <= 8'h00;
      w(22);
      chk("tmr", 32'(to[4:0]), 32'h0000_0012);
      w(26);
      chk("tmr", 32'(to[4:0]), z);
      ti <= 8'hff;
      w(40);
      chk("tmr", 32'(to[4:0]), 32'h0000_001c);
      ti <= 8'h00;
      w(4);
      chk("tmr", 32'(to[4:0]), 32'h0000_0014);
      tr <= 8'hff;
      w(2);
      tr <= 8'h00;
      w(3);
      chk("tmr", 32'(to[4:0]), z);
   endtask

   task automatic t_tot();
      for (int i = 0; i < 8; i++)
      begin
         wb(1, 9'h080 + 9'(4 * i), 32'h0003_0000);
         wb(1, 9'h0a0 + 9'(4 * i), 32'h0000_000a);
      end
      ev(2);
      for (int i = 0; i < 8; i++)
         chk("tot", total_value_out[i], 32'h0000_0006);
      ev(2);
      chk("tot", total_value_out[7], 32'h0000_000a);
      chk("fs", 32'(fs), 32'h0000_00ff);
      clr();
      chk("tot", total_value_out[3], z);
      chk("fs", 32'(fs), z);
      wb(1, 9'h080, 32'h0003_0004);
      ev(4);
      chk("tot", total_value_out[0], z);
      chk("acc", 32'(acc[0]), 32'h0000_0001);
      wb(1, 9'h080, 32'h0000_0002);
      clr();
      tn <= 8'h01;
      w(20);
      tn <= 8'h00;
      w(3);
      v0 = total_value_out[0];
      chk("tim", 32'(v0 > 3 && v0 < 7), 32'h0000_0001);
      w(20);
      chk("tim", total_value_out[0], v0);
      wb(1, 9'h080, 32'h0000_0012);
      wb(1, 9'h0c0, 32'h0000_1234);
      w(3);
      chk("hold", total_value_out[0], 32'h0000_1234);
      // Any eight edges hold exactly two ticks, so phase does not matter.
      wb(1, 9'h084, 32'h0000_0001);
      w(8);
      chk("int", total_value_out[1], 32'h0000_000a);
   endtask

   task automatic t_cmp();
      wb(1, 9'h120, 32'h0000_0064);
      a <= 16'h0096;
      w(3);
      chk("dev", 32'(dev[0]), 32'h0000_0032);
      chk("cf", 32'(cf[0]), 32'h0000_0001);
      a <= 16'h0032;
      w(3);
      chk("dev", 32'(dev[0]), 32'h0001_ffce);
      chk("cf", 32'(cf[0]), z);
      v <= 16'h0028;
      wb(1, 9'h100, 32'h0000_0002);
      w(3);
      chk("dev", 32'(dev[0]), 32'h0000_000a);
      wb(1, 9'h100, 32'h0000_0003);
      w(3);
      chk("cf", 32'(cf[0]), z);
      wb(1, 9'h100, 32'h0000_0006);
      wb(1, 9'h140, 32'h0000_0007);
      w(3);
      chk("dev", 32'(dev[0]), 32'h0000_0007);
   endtask

   task automatic t_seq();
      wb(1, 9'h160, 32'h0000_0003);
      dem <= 8'h32;
      w(4);
      chk("seq", 32'(so), 32'h0000_0003);
      chk("req", 32'(sr), 32'h0000_0032);
      dis <= 16'h0001;
      w(3);
      chk("seq", 32'(so), 32'h0000_0002);
      dis <= 16'h0000;
      dem <= 8'h64;
      wb(1, 9'h160, 32'h0000_001f);
      w(4);
      chk("seq", 32'(so), 32'h0000_ffff);
      // Logic mode, step ten: two ticks down, then one tick up.
      wb(1, 9'h160, 32'h1400_0023);
      dn <= 1'b1;
      w(8);
      dn <= 1'b0;
      w(1);
      chk("req", 32'(sr), 32'h0000_0050);
      up <= 1'b1;
      w(4);
      up <= 1'b0;
      w(1);
      chk("req", 32'(sr), 32'h0000_005a);
   endtask

   // Reset is held for twelve edges, then each scenario runs in turn.
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_tmr();
      t_tot();
      t_cmp();
      t_seq();
      test_done();
   end
endmodule
